// ===== common/decode_if.sv
// request and decode result carrier between sequencer and decoder
`timescale 1ns/100ps
interface decode_if;
  import strobe_pkg::*;
  logic [19:0] addr;
  kind_type    kind;
  logic        internal;
  logic        ram_hit;
  logic [3:0]  ctrl;
  logic [9:0]  map0;
  logic [9:0]  map1;
  logic        boot_hit;
  logic        want_ior;
  logic        want_iow;
  logic        want_mrd;
  logic        want_mwr;
  logic [1:0]  rom_ce;
  modport seq (output addr, kind, internal, ram_hit, ctrl, map0, map1,
               input boot_hit, want_ior, want_iow, want_mrd, want_mwr,
               rom_ce);
  modport dec (input addr, kind, internal, ram_hit, ctrl, map0, map1,
               output boot_hit, want_ior, want_iow, want_mrd, want_mwr,
               rom_ce);
endinterface

// ===== common/strobe_pkg.sv
// constants, register map and types of the system bus strobe decoder
package strobe_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] MAP0_OFS   = 8'h04;
  localparam logic [7:0] MAP1_OFS   = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] WAIT_OFS   = 8'h10;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_SHADOW_BIT = 0;
  localparam int CTRL_IORINH_BIT = 1;
  localparam int CTRL_IOWINH_BIT = 2;
  localparam int CTRL_ROMOE_BIT  = 3;
  localparam int MAP_PAGE_LSB    = 0;
  localparam int MAP_EN_BIT      = 8;
  localparam int MAP_ROM_BIT     = 9;
  localparam int ST_WIDTH8_BIT   = 0;
  localparam int ST_BUSY_BIT     = 1;
  localparam int ST_READY_BIT    = 2;
  localparam int ST_ROM_CHIP_ENABLE_LSB    = 3;
  // ------------------------------------------------------------
  // reset values and address windows
  // ------------------------------------------------------------
  localparam logic [3:0] CTRL_RST      = 4'h0;
  localparam logic [9:0] MAP_RST       = 10'h000;
  localparam logic [3:0] WAIT_RST      = 4'h2;
  localparam logic [3:0] BOOT_SEG_HI   = 4'hf;
  localparam int         PAGE_LSB_ADDR = 14;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_IO_RD, KIND_IO_WR, KIND_MEM_RD, KIND_MEM_WR
  } kind_type;
  typedef enum {
    ST_IDLE, ST_DECODE, ST_STROBE, ST_GAP, ST_DONE
  } cycle_state_type;
endpackage

// ===== dv/ext_dev_model.sv
// model of the external io devices and expansion memory on the strobes
`timescale 1ns/100ps
module ext_dev_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // mode and command strobes
  input  wire logic       slow,
  input  wire logic [3:0] cmd,
  // ready pin
  output logic            channel_ready_in
);
  logic [3:0] held_q;
  // ------------------------------------------------------------
  // strobe age
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      held_q <= 4'h0;
    end else if (cmd == 4'h0) begin
      held_q <= 4'h0;
    end else if (held_q != 4'hf) begin
      held_q <= held_q + 4'h1;
    end
  end
  // pulled up; a slow device pulls it low for ten strobe cycles
  assign channel_ready_in = !(slow && cmd != 4'h0 &&
                              held_q < 4'ha);
endmodule

// ===== dv/system_bus_strobe_decode_tb.sv
// self-checking bench of the system bus strobe decoder
`timescale 1ns/100ps
module system_bus_strobe_decode_tb;
  import strobe_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        cyc_start, cyc_word, cyc_internal, cyc_ram_hit;
  logic        cyc_done, cyc_busy, channel_ready_in, boot_rom_width_strap;
  kind_type    cyc_kind;
  logic [19:0] cyc_addr;
  logic        io_read_strobe, io_write_strobe, mem_read_strobe;
  logic        mem_write_strobe, byte_high, slow, strap_m;
  logic [1:0]  rom_chip_enable;
  logic [3:0]  cmd, ctrl_m, wait_m;
  logic [9:0]  map0_m, map1_m;
  integer      seed;
  int          n_mismatch, compares, cyc_cnt;
  kind_type    tk [12];
  logic [19:0] ta [12];
  logic [1:0]  tf [12];

  assign cmd = {io_read_strobe, io_write_strobe, mem_read_strobe,
                mem_write_strobe};

  system_bus_strobe_decode #(.WAIT_W(4)) u_system_bus_strobe_decode (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cyc_start(cyc_start),
    .cyc_kind(cyc_kind), .cyc_addr(cyc_addr), .cyc_word(cyc_word),
    .cyc_internal(cyc_internal), .cyc_ram_hit(cyc_ram_hit),
    .cyc_done(cyc_done), .cyc_busy(cyc_busy),
    .channel_ready_in(channel_ready_in),
    .boot_rom_width_strap(boot_rom_width_strap),
    .io_read_strobe(io_read_strobe), .io_write_strobe(io_write_strobe),
    .mem_read_strobe(mem_read_strobe), .mem_write_strobe(mem_write_strobe),
    .rom_chip_enable(rom_chip_enable), .byte_high(byte_high));

  ext_dev_model u_ext_dev_model (.clk(clk), .rst_b(rst_b), .slow(slow),
    .cmd(cmd), .channel_ready_in(channel_ready_in));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_mismatch++;
      final_report;
    end
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb_xfer(input logic wr, input logic [7:0] a,
                          input logic [31:0] wd, output logic [31:0] rd,
                          output logic er);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, n < 50}, 32'h1);
  endtask

  task automatic set_cfg(input logic [3:0] c, input logic [9:0] m0, m1,
                         input logic [3:0] w);
    logic [31:0] rd;
    logic        er;
    apb_xfer(1'b1, CTRL_OFS, {28'h0, c}, rd, er);
    apb_xfer(1'b1, MAP0_OFS, {22'h0, m0}, rd, er);
    apb_xfer(1'b1, MAP1_OFS, {22'h0, m1}, rd, er);
    apb_xfer(1'b1, WAIT_OFS, {28'h0, w}, rd, er);
    ctrl_m = c;
    map0_m = m0;
    map1_m = m1;
    wait_m = w;
  endtask

  function automatic logic [1:0] rom_of(input logic [19:0] a);
    logic [1:0] rc;
    rc = 2'b00;
    if (map0_m[8] && a[19:14] == map0_m[5:0]) rc[map0_m[9]] = 1'b1;
    if (map1_m[8] && a[19:14] == map1_m[5:0]) rc[map1_m[9]] = 1'b1;
    if (a[19:16] == BOOT_SEG_HI) rc = ctrl_m[0] ? 2'b00 : 2'b01;
    return rc;
  endfunction

  function automatic logic [5:0] exp_cmd(input kind_type k,
                                         input logic [19:0] a,
                                         input logic it, rh);
    logic [1:0] rc;
    logic       ram;
    rc = rom_of(a);
    ram = rh || (a[19:16] == BOOT_SEG_HI && ctrl_m[0]);
    case (k)
      KIND_IO_RD: return {!(it && ctrl_m[1]), 5'h00};
      KIND_IO_WR: return {1'b0, !(it && ctrl_m[2]), 4'h0};
      KIND_MEM_RD: return (rc != 2'b00) ? {2'b00, ctrl_m[3], 1'b0, rc}
                                        : {2'b00, !ram, 3'h0};
      default: return {3'h0, rc == 2'b00 && !ram, 2'b00};
    endcase
  endfunction

  task automatic run_cyc(input kind_type k, input logic [19:0] a,
                         input logic w, it, rh);
    logic [5:0]  seen, ex, mk;
    logic [31:0] m, e;
    logic        prev, bh, tkn, split;
    int          n, wid, rs, ers;
    ex = exp_cmd(k, a, it, rh);
    mk = 6'h3f;
    split = strap_m && k == KIND_MEM_RD && a[19:16] == BOOT_SEG_HI
            && !ctrl_m[0] && w;
    ers = (ex[5:2] == 4'h0) ? 0 : (split ? 2 : 1);
    seen = 6'h00;
    prev = 1'b0;
    bh = 1'b0;
    tkn = 1'b0;
    wid = 0;
    rs = 0;
    @(posedge clk);
    cyc_start <= 1'b1;
    cyc_kind <= k;
    cyc_addr <= a;
    cyc_word <= w;
    cyc_internal <= it;
    cyc_ram_hit <= rh;
    for (n = 0; n < 400; n++) begin
      @(posedge clk);
      if (tkn) cyc_start <= 1'b0;
      #1;
      tkn = tkn || cyc_busy === 1'b1;
      seen = seen | {cmd, rom_chip_enable};
      wid += (cmd != 4'h0);
      rs += (cmd != 4'h0 && !prev);
      prev = (cmd != 4'h0);
      bh = bh | byte_high;
      chk({31'h0, $countones(cmd) > 1 || (cmd != 0 && !cyc_busy)}, 0);
      if (cyc_done === 1'b1) break;
    end
    chk({31'h0, n < 400}, 32'h1);
    m = {26'h0, seen & mk};
    e = {26'h0, ex & mk};
    chk(m & 32'h30, e & 32'h30);
    chk(m & 32'h0c, e & 32'h0c);
    chk(m & 32'h03, e & 32'h03);
    chk(32'(rs), 32'(ers));
    if (ers > 0) chk({31'h0, bh}, {31'h0, ers == 2});
    if (ers > 0) chk({31'h0, slow ? wid > ers * (wait_m + 1)
                     : wid == ers * (wait_m + 1)}, 32'h1);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int          i, c;
    logic [31:0] rd, r;
    logic        er, rh;
    logic [19:0] a;
    seed = 80;
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {cyc_start, cyc_addr, cyc_word, cyc_internal, cyc_ram_hit} = '0;
    cyc_kind = KIND_IO_RD;
    {boot_rom_width_strap, slow, strap_m} = 3'b000;
    {ctrl_m, map0_m, map1_m, wait_m} = {CTRL_RST, MAP_RST, MAP_RST, WAIT_RST};
    tk = '{KIND_IO_RD, KIND_IO_RD, KIND_IO_WR, KIND_IO_WR, KIND_MEM_RD,
           KIND_MEM_RD, KIND_MEM_RD, KIND_MEM_RD, KIND_MEM_WR, KIND_MEM_WR,
           KIND_MEM_WR, KIND_MEM_WR};
    ta = '{20'h003f8, 20'h00300, 20'h003f8, 20'h00300, 20'hf1234, 20'h20010,
           20'h40000, 20'hd0000, 20'hd0000, 20'h20010, 20'h40000, 20'hf0000};
    tf = '{2'h2, 2'h0, 2'h2, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0, 2'h1,
           2'h0};
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    apb_xfer(1'b0, CTRL_OFS, 32'h0, rd, er);
    chk(rd, {28'h0, CTRL_RST});
    apb_xfer(1'b0, MAP1_OFS, 32'h0, rd, er);
    chk(rd, {22'h0, MAP_RST});
    apb_xfer(1'b0, WAIT_OFS, 32'h0, rd, er);
    chk(rd, {28'h0, WAIT_RST});
    apb_xfer(1'b1, STATUS_OFS, 32'h1b, rd, er);
    apb_xfer(1'b0, STATUS_OFS, 32'h0, rd, er);
    chk(rd, 32'h4);
    apb_xfer(1'b0, 8'h14, 32'h0, rd, er);
    chk({rd[30:0], er}, 32'h1);
    $display("test registers done");
    for (c = 0; c < 3; c++) begin
      slow <= (c == 2);
      set_cfg(c == 0 ? 4'h0 : (c == 1 ? 4'hf : 4'h8), 10'h308, 10'h000,
              c == 2 ? 4'h6 : 4'h1);
      for (i = 0; i < 12; i++) run_cyc(tk[i], ta[i], 1'b1, tf[i][1], tf[i][0]);
      $display("test corner set %0d done", c);
    end
    for (i = 0; i < 48; i++) begin
      r = $random(seed);
      if (i % 8 == 0) begin
        slow <= r[4];
        set_cfg(r[3:0], {r[5], r[6], 3'b000, r[11:7]},
                {~r[5], r[12], 3'b000, r[11:7] ^ 5'h10},
                r[4] ? 4'h6 : {2'b00, r[14:13]});
        r = $random(seed);
      end
      a = r[19:0] & 20'h7ffff;
      if (r[21:20] == 2'd0) a[19:16] = BOOT_SEG_HI;
      if (r[21:20] == 2'd1) a[19:14] = map0_m[5:0];
      rh = r[22] && rom_of(a) == 2'b00;
      run_cyc(kind_type'(r[24:23]), a, r[25], r[26], rh);
    end
    $display("test random done");
    rst_b <= 1'b0;
    slow <= 1'b0;
    boot_rom_width_strap <= 1'b1;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    strap_m = 1'b1;
    repeat (4) @(posedge clk);
    apb_xfer(1'b0, STATUS_OFS, 32'h0, rd, er);
    chk(rd & 32'h1, 32'h1);
    set_cfg(4'h8, MAP_RST, MAP_RST, 4'h2);
    run_cyc(KIND_MEM_RD, 20'hf0010, 1'b1, 1'b0, 1'b0);
    run_cyc(KIND_MEM_RD, 20'hf0010, 1'b0, 1'b0, 1'b0);
    $display("test narrow boot rom done");
    final_report;
  end
endmodule

// ===== hw/strobe_target_decode.sv
// address and option decode of one bus cycle into strobes and enables
`timescale 1ns/100ps
module strobe_target_decode (
  // request and result
  decode_if.dec d
);
  import strobe_pkg::*;

  // ------------------------------------------------------------
  // window hit
  // ------------------------------------------------------------
  function automatic logic page_hit(input logic [9:0] map,
                                    input logic [19:0] a);
    page_hit = map[MAP_EN_BIT] &&
               (a[19:PAGE_LSB_ADDR] == map[MAP_PAGE_LSB +: 6]);
  endfunction

  logic hit0, hit1, shadow, is_ram, is_rom, rd;

  always_comb begin
    hit0       = page_hit(d.map0, d.addr);
    hit1       = page_hit(d.map1, d.addr);
    d.boot_hit = d.addr[19:16] == BOOT_SEG_HI;
    shadow     = d.ctrl[CTRL_SHADOW_BIT] && d.boot_hit;
    is_ram     = d.ram_hit || shadow;
    is_rom     = !is_ram && (d.boot_hit || hit0 || hit1);
    rd         = d.kind == KIND_MEM_RD;
    d.rom_ce[0] = rd && is_rom &&
                  (d.boot_hit || (hit0 && !d.map0[MAP_ROM_BIT]) ||
                   (hit1 && !d.map1[MAP_ROM_BIT]));
    d.rom_ce[1] = rd && is_rom && !d.boot_hit &&
                  ((hit0 && d.map0[MAP_ROM_BIT]) ||
                   (hit1 && d.map1[MAP_ROM_BIT]));
    d.want_ior = d.kind == KIND_IO_RD &&
                 !(d.internal && d.ctrl[CTRL_IORINH_BIT]);
    d.want_iow = d.kind == KIND_IO_WR &&
                 !(d.internal && d.ctrl[CTRL_IOWINH_BIT]);
    d.want_mrd = rd && !is_ram &&
                 (!is_rom || d.ctrl[CTRL_ROMOE_BIT]);
    d.want_mwr = d.kind == KIND_MEM_WR && !is_ram &&
                 !(d.boot_hit || hit0 || hit1);
  end
endmodule

// ===== hw/system_bus_strobe_decode.sv
// system bus command strobes and rom chip enables with apb registers
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps
// Notes on behaviour
// - rom 0 enable for boot window reads when window is not shadowed
// - two mapped windows may enable either rom for other ranges
// - io read strobe asks external io device to drive the data bus
// - io read strobe can be inhibited for internal io targets
// - io write strobe marks valid write data on the data bus
// - io write strobe can be inhibited for internal io targets
// - memory read strobe for external memory, never for system ram
// - option lets memory read strobe act as rom output enable
// - memory write strobe for writes to expansion memory
// - no memory write strobe for ram or rom targets
// - external channel ready not-ready adds wait states to the cycle
// - strap picks 16 or 8 bit boot rom; 8 bit splits words
module system_bus_strobe_decode #(
  parameter int WAIT_W = 4
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // bus cycle request
  input  wire logic               cyc_start,
  input  wire strobe_pkg::kind_type cyc_kind,
  input  wire logic [19:0]        cyc_addr,
  input  wire logic               cyc_word,
  input  wire logic               cyc_internal,
  input  wire logic               cyc_ram_hit,
  output logic                    cyc_done,
  output logic                    cyc_busy,
  // pins
  input  wire logic               channel_ready_in,
  input  wire logic               boot_rom_width_strap,
  output logic                    io_read_strobe,
  output logic                    io_write_strobe,
  output logic                    mem_read_strobe,
  output logic                    mem_write_strobe,
  output logic [1:0]              rom_chip_enable,
  output logic                    byte_high
);
  import strobe_pkg::*;

  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  if (WAIT_W < 4 || WAIT_W > 8) begin : g_bad_w
    $error("WAIT_W must lie between 4 and 8");
  end

  decode_if dif ();

  strobe_target_decode u_dec (
    .d (dif.dec)
  );

  logic [3:0]        ctrl_q;
  logic [9:0]        map0_q;
  logic [9:0]        map1_q;
  logic [WAIT_W-1:0] wait_q;
  logic [2:0]        rdy_sync_q;
  logic [2:0]        strap_sync_q, strap_fill_q;
  logic              chan_ready_q;
  logic              width8_q;
  logic              strap_done_q;
  cycle_state_type   state_q;
  cycle_state_type   state_d;
  logic [WAIT_W-1:0] cnt_q;
  logic [19:0]       req_addr_q;
  kind_type          req_kind_q;
  logic              req_word_q;
  logic              req_int_q;
  logic              req_ram_q;
  logic              second_q;
  logic              split;
  logic              strobe_end;
  logic              take;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdy_sync_q   <= 3'h0;
      strap_sync_q <= 3'h0;
      strap_fill_q <= 3'h0;
    end else begin
      rdy_sync_q   <= {rdy_sync_q[1:0], channel_ready_in};
      strap_sync_q <= {strap_sync_q[1:0], boot_rom_width_strap};
      strap_fill_q <= {strap_fill_q[1:0], 1'b1};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_ready_q <= 1'b0;
    end else if (rdy_sync_q[1] == rdy_sync_q[2]) begin
      chan_ready_q <= rdy_sync_q[2];
    end
  end

  // strap caught once after reset release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      width8_q     <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q && strap_sync_q[1] == strap_sync_q[2]
                 && strap_fill_q[2] && state_q == ST_IDLE) begin
      width8_q     <= strap_sync_q[2];
      strap_done_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // apb registers
  // ------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    mapped = a == CTRL_OFS || a == MAP0_OFS || a == MAP1_OFS ||
             a == STATUS_OFS || a == WAIT_OFS;
  endfunction

  logic wr_en;
  assign wr_en = psel && penable && pready && pwrite && !pslverr;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped(paddr);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      unique case (paddr)
        CTRL_OFS:   prdata[3:0] <= ctrl_q;
        MAP0_OFS:   prdata[9:0] <= map0_q;
        MAP1_OFS:   prdata[9:0] <= map1_q;
        WAIT_OFS:   prdata[WAIT_W-1:0] <= wait_q;
        STATUS_OFS: begin
          prdata[ST_WIDTH8_BIT] <= width8_q;
          prdata[ST_BUSY_BIT]   <= state_q != ST_IDLE;
          prdata[ST_READY_BIT]  <= chan_ready_q;
          prdata[ST_ROM_CHIP_ENABLE_LSB +: 2] <= rom_chip_enable;
        end
        default:    prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RST;
      map0_q <= MAP_RST;
      map1_q <= MAP_RST;
      wait_q <= WAIT_W'(WAIT_RST);
    end else if (wr_en) begin
      unique case (paddr)
        CTRL_OFS: ctrl_q <= pwdata[3:0];
        MAP0_OFS: map0_q <= pwdata[9:0];
        MAP1_OFS: map1_q <= pwdata[9:0];
        WAIT_OFS: wait_q <= pwdata[WAIT_W-1:0];
        default:  ctrl_q <= ctrl_q;
      endcase
    end
  end

  // ------------------------------------------------------------
  // request capture and decode hookup
  // ------------------------------------------------------------
  assign take = state_q == ST_IDLE && cyc_start && strap_done_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_addr_q <= 20'h00000;
      req_kind_q <= KIND_IO_RD;
      req_word_q <= 1'b0;
      req_int_q  <= 1'b0;
      req_ram_q  <= 1'b0;
    end else if (take) begin
      req_addr_q <= cyc_addr;
      req_kind_q <= cyc_kind;
      req_word_q <= cyc_word;
      req_int_q  <= cyc_internal;
      req_ram_q  <= cyc_ram_hit;
    end
  end

  assign dif.addr     = req_addr_q;
  assign dif.kind     = req_kind_q;
  assign dif.internal = req_int_q;
  assign dif.ram_hit  = req_ram_q;
  assign dif.ctrl     = ctrl_q;
  assign dif.map0     = map0_q;
  assign dif.map1     = map1_q;

  // ------------------------------------------------------------
  // cycle sequencer
  // ------------------------------------------------------------
  // 8 bit boot rom answers a word read in two byte strobes
  assign split = width8_q && req_word_q && dif.rom_ce[0] &&
                 dif.boot_hit;
  // internal count and external ready both must release the cycle
  assign strobe_end = cnt_q == '0 && chan_ready_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:   if (take) state_d = ST_DECODE;
      ST_DECODE: state_d = ST_STROBE;
      ST_STROBE: if (strobe_end) begin
        state_d = (split && !second_q) ? ST_GAP : ST_DONE;
      end
      ST_GAP:    state_d = ST_STROBE;
      ST_DONE:   state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else if (state_q == ST_DECODE || state_q == ST_GAP) begin
      cnt_q <= wait_q;
    end else if (state_q == ST_STROBE && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      second_q <= 1'b0;
    end else if (state_q == ST_GAP) begin
      second_q <= 1'b1;
    end else if (state_q == ST_IDLE) begin
      second_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // strobe and enable outputs
  // ------------------------------------------------------------
  logic in_strobe, in_cycle;
  assign in_strobe = state_d == ST_STROBE;
  assign in_cycle  = state_d == ST_STROBE || state_d == ST_GAP;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io_read_strobe   <= 1'b0;
      io_write_strobe  <= 1'b0;
      mem_read_strobe  <= 1'b0;
      mem_write_strobe <= 1'b0;
    end else begin
      io_read_strobe   <= in_strobe && dif.want_ior;
      io_write_strobe  <= in_strobe && dif.want_iow;
      mem_read_strobe  <= in_strobe && dif.want_mrd;
      mem_write_strobe <= in_strobe && dif.want_mwr;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rom_chip_enable <= 2'h0;
      byte_high       <= 1'b0;
    end else begin
      rom_chip_enable <= in_cycle ? dif.rom_ce : 2'h0;
      byte_high       <= in_strobe && (second_q || state_q == ST_GAP);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_done <= 1'b0;
      cyc_busy <= 1'b0;
    end else begin
      cyc_done <= state_q == ST_DONE;
      cyc_busy <= state_d != ST_IDLE;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  chk_one_command: assert property (
    $onehot0({io_read_strobe, io_write_strobe,
              mem_read_strobe, mem_write_strobe}))
    else $error("more than one command strobe active");
  chk_strobe_in_cycle: assert property (
    (io_read_strobe || mem_read_strobe || rom_chip_enable != 2'h0)
      |-> state_q == ST_STROBE || state_q == ST_GAP)
    else $error("strobe outside a bus cycle");
  chk_boot_rom_ce: assert property (
    state_q == ST_DECODE && req_kind_q == KIND_MEM_RD && !req_ram_q &&
    req_addr_q[19:16] == BOOT_SEG_HI && !ctrl_q[CTRL_SHADOW_BIT]
      |=> rom_chip_enable[0])
    else $error("boot read did not enable rom 0");
  chk_shadow_quiet: assert property (
    state_q != ST_IDLE && req_addr_q[19:16] == BOOT_SEG_HI &&
    ctrl_q[CTRL_SHADOW_BIT] |-> !rom_chip_enable[0] && !mem_read_strobe)
    else $error("shadowed boot window reached rom");
  chk_map_rom1: assert property (
    rom_chip_enable[1] |-> req_kind_q == KIND_MEM_RD &&
    ((map0_q[MAP_EN_BIT] && map0_q[MAP_ROM_BIT]) ||
     (map1_q[MAP_EN_BIT] && map1_q[MAP_ROM_BIT])))
    else $error("rom 1 enabled without a mapped window");
  chk_ior_issue: assert property (
    state_q == ST_DECODE && req_kind_q == KIND_IO_RD && !req_int_q
      |=> io_read_strobe)
    else $error("external io read lacks strobe");
  chk_ior_inhibit: assert property (
    io_read_strobe |-> !(req_int_q && ctrl_q[CTRL_IORINH_BIT]))
    else $error("inhibited io read strobed");
  chk_iow_issue: assert property (
    state_q == ST_DECODE && req_kind_q == KIND_IO_WR && !req_int_q
      |=> io_write_strobe)
    else $error("external io write lacks strobe");
  chk_iow_inhibit: assert property (
    io_write_strobe |-> !(req_int_q && ctrl_q[CTRL_IOWINH_BIT]))
    else $error("inhibited io write strobed");
  chk_mrd_ram: assert property (
    mem_read_strobe |-> !req_ram_q)
    else $error("memory read strobe on system ram");
  chk_mrd_rom_oe: assert property (
    mem_read_strobe && rom_chip_enable != 2'h0 |->
      ctrl_q[CTRL_ROMOE_BIT])
    else $error("rom read strobed without oe option");
  chk_mwr_target: assert property (
    mem_write_strobe |-> !req_ram_q &&
      req_addr_q[19:16] != BOOT_SEG_HI)
    else $error("memory write strobe on ram or rom");
  chk_wait_hold: assert property (
    state_q == ST_STROBE && !chan_ready_q |=> state_q == ST_STROBE)
    else $error("cycle ended while channel not ready");
  chk_byte_split: assert property (
    byte_high |-> width8_q && req_word_q)
    else $error("second byte without 8 bit rom word");

  cov_io_read:   cover property (io_read_strobe ##1 !io_read_strobe);
  cov_wait:      cover property (state_q == ST_STROBE && !chan_ready_q);
  cov_split:     cover property (state_q == ST_GAP);
  cov_rom1:      cover property (rom_chip_enable[1]);
endmodule
